// file: rtl/reg_word_mem.sv
`timescale 1ns/1ps
`default_nettype none

// general user register words; read data leave a register one edge later
module reg_word_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [5:0] raddr,
	output logic [15:0] rdata
);
	import term_reg_pkg::*;

	logic [15:0] words [0:REG_COUNT-1];

	// no reset on the array, so unwritten words read undefined
	always_ff @(posedge clk) begin
		if (we) begin
			words[waddr] <= wdata;
		end
		rdata <= words[raddr];
	end

endmodule

`default_nettype wire

// file: rtl/term_reg_pkg.sv
package term_reg_pkg;

	// control byte field positions
	localparam int REG_ACCESS_BIT = 7;
	localparam int WRITE_BIT = 6;
	localparam int NUMBER_MSB = 5;
	localparam int NUMBER_LSB = 0;

	// register numbers and widths
	localparam int NUMBER_W = 6;
	localparam int WORD_W = 16;
	localparam int REG_COUNT = 64;
	localparam logic [5:0] CODE_WORD_NUM = 6'h1f;
	localparam logic [5:0] FEATURE_NUM = 6'h20;

	// code word values and reset values
	localparam logic [15:0] UNLOCK_CODE = 16'h1235;
	localparam logic [15:0] LOCK_CODE = 16'h0000;
	localparam logic [15:0] CODE_WORD_RESET = 16'h0000;
	localparam logic [15:0] FEATURE_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] IN_WORD_RESET = 16'h0000;

	// request from the controller: control byte plus output word
	typedef struct packed {
		logic [7:0] control_byte;
		logic [15:0] host_out_word;
	} host_req_t;

	// answer to the controller: status byte plus input word
	typedef struct packed {
		logic [7:0] status_byte;
		logic [15:0] terminal_in_word;
	} term_ans_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ_WAIT,
		ST_HOLD
	} access_state_t;

	function automatic logic is_reg_access(input logic [7:0] ctrl);
		return ctrl[REG_ACCESS_BIT];
	endfunction

	function automatic logic is_write(input logic [7:0] ctrl);
		return ctrl[WRITE_BIT];
	endfunction

	function automatic logic [5:0] register_number_field(input logic [7:0] ctrl);
		return ctrl[NUMBER_MSB:NUMBER_LSB];
	endfunction

endpackage

// file: rtl/terminal_register_access.sv
`timescale 1ns/1ps
`default_nettype none

module terminal_register_access (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire term_reg_pkg::host_req_t HOST_REQ,
	input wire term_reg_pkg::term_ans_t PROCESS_ANS,
	input wire logic RESTART,
	output term_reg_pkg::term_ans_t TERM_ANS,
	output logic [15:0] FEATURE_ACTIVE,
	output logic WRITE_UNLOCKED
);
	import term_reg_pkg::*;

	// which storage a register number lands in
	typedef enum logic [1:0] {
		TGT_CODE,
		TGT_FEATURE,
		TGT_PLAIN
	} target_t;

	// shared by the write path and the read path so both agree on the map
	function automatic target_t reg_target(input logic [5:0] number);
		if (number == CODE_WORD_NUM) begin
			return TGT_CODE;
		end else if (number == FEATURE_NUM) begin
			return TGT_FEATURE;
		end else begin
			return TGT_PLAIN;
		end
	endfunction

	// sequencer state
	access_state_t state, next_state;
	logic [7:0] held_ctrl, next_held_ctrl;

	// stored registers
	logic [15:0] code_word, next_code_word;
	logic [15:0] feature_config, next_feature_config;
	logic [15:0] feature_active, next_feature_active;

	// answer towards the controller
	term_ans_t answer, next_answer;

	// request decode
	logic [7:0] ctrl;
	logic [5:0] num;
	logic [5:0] held_num;
	target_t target;
	target_t held_target;
	logic take;
	logic take_write;
	logic take_read;
	logic unlocked;
	logic mem_we;
	logic [15:0] mem_rdata;

	assign ctrl = HOST_REQ.control_byte;
	assign num = register_number_field(ctrl);
	assign held_num = register_number_field(held_ctrl);
	assign target = reg_target(num);
	assign held_target = reg_target(held_num);
	assign unlocked = (code_word == UNLOCK_CODE);

	// a request is taken only from idle and only with the access bit set
	assign take = (state == ST_IDLE) && is_reg_access(ctrl);
	assign take_write = take && is_write(ctrl);
	assign take_read = take && !is_write(ctrl);

	// plain words other than code word and feature register
	reg_word_mem mem (
		.clk(CORE_CLK),
		.we(mem_we),
		.waddr(num),
		.wdata(HOST_REQ.host_out_word),
		.raddr(num),
		.rdata(mem_rdata)
	);

	// sequencer: idle, one wait edge for the registered memory word, then hold
	always_comb begin
		next_state = state;
		next_held_ctrl = held_ctrl;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_held_ctrl = ctrl;
				end
				// writes answer at once, reads wait for the memory word
				if (take_write) begin
					next_state = ST_HOLD;
				end else if (take_read) begin
					next_state = ST_READ_WAIT;
				end
			end
			ST_READ_WAIT: begin
				next_state = ST_HOLD;
			end
			ST_HOLD: begin
				// an unchanged request is never served twice
				if (ctrl != held_ctrl) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state <= ST_IDLE;
			held_ctrl <= STATUS_RESET;
		end else begin
			state <= next_state;
			held_ctrl <= next_held_ctrl;
		end
	end

	// register writes; the code word stays open so it can always unlock
	always_comb begin
		next_code_word = code_word;
		next_feature_config = feature_config;
		next_feature_active = feature_active;
		mem_we = 1'b0;
		if (take_write) begin
			case (target)
				TGT_CODE: begin
					// any value but the unlock code locks again
					next_code_word = HOST_REQ.host_out_word;
				end
				TGT_FEATURE: begin
					if (unlocked) begin
						next_feature_config = HOST_REQ.host_out_word;
					end
				end
				TGT_PLAIN: begin
					if (unlocked) begin
						mem_we = 1'b1;
					end
				end
				default: begin
					mem_we = 1'b0;
				end
			endcase
			// locked writes are dropped here; the answer path still receipts them
		end
		// staged configuration reaches the terminal only on restart
		if (RESTART) begin
			next_feature_active = feature_config;
		end
	end

	// stored registers; lock changes act at once, only the feature set waits
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			code_word <= CODE_WORD_RESET;
			feature_config <= FEATURE_RESET;
			feature_active <= FEATURE_RESET;
		end else begin
			code_word <= next_code_word;
			feature_config <= next_feature_config;
			feature_active <= next_feature_active;
		end
	end

	// answer: receipts, read data, or the process image copied through
	always_comb begin
		next_answer = answer;
		case (state)
			ST_IDLE: begin
				if (take_write) begin
					// input word kept as it was; it means nothing after a write
					next_answer.status_byte = ctrl & ~(8'h01 << WRITE_BIT);
				end else if (!take) begin
					next_answer = PROCESS_ANS;
				end
				// a fresh read leaves the answer alone until its word is ready
			end
			ST_READ_WAIT: begin
				next_answer.status_byte = held_ctrl;
				// high byte lands in bits 15..8; the output word is never looked at
				case (held_target)
					TGT_CODE: begin
						next_answer.terminal_in_word = code_word;
					end
					TGT_FEATURE: begin
						next_answer.terminal_in_word = feature_config;
					end
					default: begin
						next_answer.terminal_in_word = mem_rdata;
					end
				endcase
			end
			ST_HOLD: begin
				next_answer = answer;
			end
			default: begin
				next_answer = answer;
			end
		endcase
	end

	// answer register
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			answer <= {STATUS_RESET, IN_WORD_RESET};
		end else begin
			answer <= next_answer;
		end
	end

	assign TERM_ANS = answer;
	assign FEATURE_ACTIVE = feature_active;
	assign WRITE_UNLOCKED = unlocked;

endmodule

`default_nettype wire

// file: tb/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	input wire logic clk,
	input wire term_reg_pkg::term_ans_t rsp,
	output var term_reg_pkg::host_req_t req
);
	import term_reg_pkg::*;
	initial req = '0;
	// holds a request until its receipt shows or 8 cycles pass, then parks in process mode
	task automatic access(input logic [7:0] cb, input logic [15:0] w, output term_ans_t ans);
		logic [7:0] ack;
		ack = cb[6] ? (cb & 8'hbf) : cb;
		@(negedge clk);
		req = {cb, w};
		ans = '0;
		for (int i = 0; i < 8 && ans.status_byte !== ack; i++) begin
			@(negedge clk);
			ans = rsp;
		end
		req = {8'h00, ~w};
		repeat (2) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// file: tb/term_reg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module term_reg_chk (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire term_reg_pkg::host_req_t HOST_REQ,
	input wire term_reg_pkg::term_ans_t PROCESS_ANS,
	input wire logic RESTART,
	input wire term_reg_pkg::term_ans_t TERM_ANS,
	input wire logic [15:0] FEATURE_ACTIVE,
	input wire logic WRITE_UNLOCKED
);
	import term_reg_pkg::*;
	logic [7:0] cb;
	assign cb = HOST_REQ.control_byte;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// answers tied to the request that caused them, or to the process image when no request is seen
	proc_copy_a: assert property (!cb[7] ##1 !cb[7] |=> TERM_ANS == $past(PROCESS_ANS)) else $error("bad copy");
	// a request fresh out of process mode is taken at once; the controller drops it on the receipt
	wr_ack_a: assert property (cb[7:6] == 2'b11 && !$past(cb[7]) |=>
		TERM_ANS.status_byte == ($past(cb) & 8'hbf)) else $error("bad write receipt");
	rd_ack_a: assert property (cb[7:6] == 2'b10 && !$past(cb[7]) |-> ##2
		TERM_ANS.status_byte == $past(cb, 2)) else $error("bad read receipt");
	wr_bit6_a: assert property ($changed(TERM_ANS.status_byte) && $past(cb[7:6]) == 2'b11 |->
		!TERM_ANS.status_byte[6]) else $error("bit 6 set");
	// lock state moves only on a code word write
	unlock_entry_a: assert property ($rose(WRITE_UNLOCKED) |->
		$past(cb) == 8'hdf && $past(HOST_REQ.host_out_word) == UNLOCK_CODE) else $error("bad unlock");
	relock_entry_a: assert property ($fell(WRITE_UNLOCKED) |-> $past(cb) == 8'hdf) else $error("bad relock");
	code_hold_a: assert property ($past(cb) != 8'hdf |-> $stable(WRITE_UNLOCKED)) else $error("lock moved");
	feat_hold_a: assert property (!RESTART |=> $stable(FEATURE_ACTIVE)) else $error("feature moved");
	cover property (cb == 8'hdf ##1 WRITE_UNLOCKED);
	cover property (cb == 8'ha0 ##2 TERM_ANS.status_byte == 8'ha0);
	cover property ($rose(RESTART));
endmodule
bind terminal_register_access term_reg_chk term_reg_chk_inst (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.HOST_REQ(HOST_REQ),
	.PROCESS_ANS(PROCESS_ANS),
	.RESTART(RESTART),
	.TERM_ANS(TERM_ANS),
	.FEATURE_ACTIVE(FEATURE_ACTIVE),
	.WRITE_UNLOCKED(WRITE_UNLOCKED)
);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import term_reg_pkg::*;
	logic clk, rst, restart, unl;
	host_req_t req;
	term_ans_t pans, ans, got;
	logic [15:0] feat, v, f;
	logic [5:0] n;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	terminal_register_access terminal_register_access_inst (.CORE_CLK(clk), .RST(rst), .HOST_REQ(req),
		.PROCESS_ANS(pans), .RESTART(restart), .TERM_ANS(ans), .FEATURE_ACTIVE(feat), .WRITE_UNLOCKED(unl));
	ctrl_model ctrl_model_inst (.clk(clk), .rsp(ans), .req(req));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] seen);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude;
		if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// receipt for register a: access bit set, direction bit clear, number kept
	function automatic logic [7:0] receipt(input logic [5:0] a);
		return {2'b10, a};
	endfunction
	// input word after a write is not looked at
	task automatic wr(input logic [5:0] a, input logic [15:0] w);
		ctrl_model_inst.access({2'b11, a}, w, got);
		check("receipt", {receipt(a), 16'h0}, {got.status_byte, 16'h0});
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] w);
		ctrl_model_inst.access({2'b10, a}, 16'($urandom), got);
		check("read", {receipt(a), w}, got);
	endtask
	// hang guard, far above the roughly 120 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		rst = 1;
		restart = 0;
		pans = '0;
		void'($urandom(32'hc3dd2cfa));
		repeat (5) @(negedge clk);
		rst = 0;
		rd(6'h1f, 16'h0000);
		wr(6'h20, 16'h5a5a);
		rd(6'h20, 16'h0000);
		wr(6'h1f, UNLOCK_CODE);
		check("unlocked", 24'h1, {23'h0, unl});
		rd(6'h1f, UNLOCK_CODE);
		f = 16'($urandom);
		wr(6'h20, f);
		rd(6'h20, f);
		check("early", 24'h0, {8'h0, feat});
		@(negedge clk) restart = 1;
		@(negedge clk) restart = 0;
		check("feature", {8'h0, f}, {8'h0, feat});
		repeat (6) begin
			n = 6'($urandom_range(30));
			v = 16'($urandom);
			wr(n, v);
			rd(n, v);
		end
		wr(6'h1f, LOCK_CODE);
		check("locked", 24'h0, {23'h0, unl});
		// a plain word must also refuse writes once locked
		wr(n, ~v);
		rd(n, v);
		wr(6'h20, ~f);
		rd(6'h20, f);
		pans = {1'b0, 23'($urandom)};
		repeat (3) @(negedge clk);
		check("process", pans, ans);
		conclude();
	end
endmodule
`default_nettype wire
